// [core/cpu_ea_alu.sv]
// Functional notes
// - postbyte picks mode, variation and pointer
// - zero offset uses pointer as address
// - constant offset added, pointer kept
// - 5, 8, 16-bit signed offsets extended
// - shortest offset lives inside the postbyte
// - signed A, B or D offset added
// - accumulator offset changes neither register
// - auto step adds one or two afterwards, or subtracts one or two first
// - indirection except single step, short offset
// - taken branch loads pc plus signed offset
// - all address sums wrap at 16 bits
// - pc relative adds 8/16-bit offset to pc
// - load address writes address into pointer
// - unsigned A times B into D
// - swap/copy among A, B, flags, page base
// - swap/copy D with pointers and pc
// - A filled with sign of B
// - 16-bit add, subtract, compare, load, store
// - 8-bit add/subtract with and without carry
// - arithmetic, logical shifts and rotates
// - decimal adjust of A to packed BCD
// - push and pull on either stack
// - D is A high byte, B low
`timescale 1ns/10ps
`default_nettype none
module cpu_ea_alu (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic op_valid,
    input wire cpu_pkg::op_t op,
    input wire logic [7:0] postbyte,
    input wire logic [15:0] operand,
    input wire logic sel_b,
    input wire logic to_mem,
    input wire logic wide,
    input wire logic cond_true,
    input wire logic user_stack,
    input wire logic [1:0] lea_dst,
    output logic [15:0] ea_r,
    output logic ea_indirect_r,
    output logic wr_en_r,
    output logic [15:0] wr_addr_r,
    output logic [15:0] wr_data_r,
    output logic [15:0] acc_d,
    output logic [7:0] condition_flags,
    output logic [7:0] page_base,
    output logic [15:0] index_x,
    output logic [15:0] index_y,
    output logic [15:0] user_sp,
    output logic [15:0] hw_sp,
    output logic [15:0] prog_counter
);
    logic [7:0] a_r, b_r, fl_r, pg_r;
    logic [15:0] x_r, y_r, u_r, s_r, pc_r;
    logic [7:0] a_nxt, b_nxt, fl_nxt, pg_nxt;
    logic [15:0] x_nxt, y_nxt, u_nxt, s_nxt, pc_nxt;
    logic [15:0] ea_nxt, wr_addr_nxt, wr_data_nxt;
    logic ea_indirect_nxt, wr_en_nxt;

    ea_if eab();
    assign eab.postbyte = postbyte;
    assign eab.acc_a = a_r;
    assign eab.acc_b = b_r;
    assign eab.x = x_r;
    assign eab.y = y_r;
    assign eab.u = u_r;
    assign eab.s = s_r;
    assign eab.pc = pc_r;
    assign eab.operand = operand;
    ea_calc u_ea (.bus(eab));

    // output views straight from the flops
    assign acc_d = {a_r, b_r};
    assign condition_flags = fl_r;
    assign page_base = pg_r;
    assign index_x = x_r;
    assign index_y = y_r;
    assign user_sp = u_r;
    assign hw_sp = s_r;
    assign prog_counter = pc_r;

    // register read by code; 8-bit sources pad the high byte with ones
    function automatic logic [15:0] rd(input logic [3:0] code, input logic [7:0] a,
                                       input logic [7:0] b, input logic [7:0] fl,
                                       input logic [7:0] pg, input logic [15:0] x,
                                       input logic [15:0] y, input logic [15:0] u,
                                       input logic [15:0] s, input logic [15:0] pc);
        unique case (code)
            cpu_pkg::RC_D: rd = {a, b};
            cpu_pkg::RC_X: rd = x;
            cpu_pkg::RC_Y: rd = y;
            cpu_pkg::RC_U: rd = u;
            cpu_pkg::RC_S: rd = s;
            cpu_pkg::RC_PC: rd = pc;
            cpu_pkg::RC_A: rd = {8'hFF, a};
            cpu_pkg::RC_B: rd = {8'hFF, b};
            cpu_pkg::RC_FL: rd = {8'hFF, fl};
            cpu_pkg::RC_PG: rd = {8'hFF, pg};
            default: rd = 16'hFFFF; // undefined codes read all ones
        endcase
    endfunction : rd

    // operand selection shared by the 8-bit and 16-bit paths
    wire logic [3:0] src_code = postbyte[7:4];
    wire logic [3:0] dst_code = postbyte[3:0];
    wire logic [15:0] src_val = rd(src_code, a_r, b_r, fl_r, pg_r, x_r, y_r, u_r, s_r, pc_r);
    wire logic [15:0] dst_val = rd(dst_code, a_r, b_r, fl_r, pg_r, x_r, y_r, u_r, s_r, pc_r);
    wire logic size_match = src_code[cpu_pkg::RC_NARROW_BIT] == dst_code[cpu_pkg::RC_NARROW_BIT];
    wire logic [7:0] acc8 = sel_b ? b_r : a_r;
    wire logic [7:0] src8 = to_mem ? operand[7:0] : acc8;
    wire logic [7:0] m8 = operand[7:0];
    wire logic carry_in = fl_r[cpu_pkg::FL_C];
    wire logic [15:0] br_off = wide ? operand : {{8{operand[7]}}, operand[7:0]};
    wire logic [15:0] sp_cur = user_stack ? u_r : s_r;
    wire logic push_narrow = dst_code[cpu_pkg::RC_NARROW_BIT];
    wire logic [15:0] sp_step = push_narrow ? cpu_pkg::STEP_ONE : cpu_pkg::STEP_TWO;
    wire logic [3:0] sp_code = user_stack ? cpu_pkg::RC_U : cpu_pkg::RC_S;
    wire logic [3:0] lea_code = {2'b00, lea_dst} + 4'h1;

    // 8-bit arithmetic: carry or borrow only for the carry forms
    wire logic use_c = (op == cpu_pkg::add8_carry_op) || (op == cpu_pkg::sub8_borrow_op);
    wire logic is_sub = (op == cpu_pkg::sub8_op) || (op == cpu_pkg::sub8_borrow_op) ||
                        (op == cpu_pkg::compare8_op);
    wire logic [8:0] cin9 = {8'h00, use_c & carry_in};
    wire logic [8:0] sum9 = is_sub ? {1'b0, acc8} - {1'b0, m8} - cin9
                                   : {1'b0, acc8} + {1'b0, m8} + cin9;
    wire logic v8 = is_sub ? (acc8[7] ^ m8[7]) & (acc8[7] ^ sum9[7])
                           : ~(acc8[7] ^ m8[7]) & (acc8[7] ^ sum9[7]);
    wire logic h8 = acc8[4] ^ m8[4] ^ sum9[4];

    // 16-bit arithmetic on D against a memory word
    wire logic [15:0] d_cur = {a_r, b_r};
    wire logic wsub = op != cpu_pkg::wide_add_op;
    wire logic [16:0] sum17 = wsub ? {1'b0, d_cur} - {1'b0, operand}
                                   : {1'b0, d_cur} + {1'b0, operand};
    wire logic v16 = wsub ? (d_cur[15] ^ operand[15]) & (d_cur[15] ^ sum17[15])
                          : ~(d_cur[15] ^ operand[15]) & (d_cur[15] ^ sum17[15]);

    // shifter; left shift overflow is bit 7 xor bit 6
    logic [7:0] sh8;
    logic sh_c;
    always_comb begin
        sh8 = src8;
        sh_c = carry_in;
        unique case (op)
            cpu_pkg::shift_right_arith_op: {sh8, sh_c} = {src8[7], src8};
            cpu_pkg::shift_right_logic_op: {sh8, sh_c} = {1'b0, src8};
            cpu_pkg::rotate_right_op: {sh8, sh_c} = {carry_in, src8};
            cpu_pkg::shift_left_op: {sh_c, sh8} = {src8, 1'b0};
            cpu_pkg::rotate_left_op: {sh_c, sh8} = {src8, carry_in};
            default: sh8 = src8;
        endcase
    end

    // decimal adjust: add 6 per digit that overflowed or went past 9
    wire logic lo_fix = fl_r[cpu_pkg::FL_H] || (a_r[3:0] > 4'h9);
    wire logic hi_fix = carry_in || (a_r[7:4] > 4'h9) || (a_r[7:4] > 4'h8 && a_r[3:0] > 4'h9);
    wire logic [8:0] adj9 = {1'b0, a_r} + {2'b00, hi_fix, hi_fix, 2'b00, lo_fix, lo_fix, 1'b0};
    wire logic [15:0] prod = {8'h00, a_r} * {8'h00, b_r};

    // two generic register write ports; port 1 has the last word
    logic [1:0] p_en;
    logic [3:0] p_code [2];
    logic [15:0] p_val [2];

    always_comb begin
        {a_nxt, b_nxt, fl_nxt, pg_nxt} = {a_r, b_r, fl_r, pg_r};
        {x_nxt, y_nxt, u_nxt, s_nxt, pc_nxt} = {x_r, y_r, u_r, s_r, pc_r};
        ea_nxt = ea_r;
        ea_indirect_nxt = ea_indirect_r;
        wr_en_nxt = 1'b0;
        wr_addr_nxt = wr_addr_r;
        wr_data_nxt = wr_data_r;
        p_en = 2'b00;
        p_code[0] = cpu_pkg::RC_D;
        p_code[1] = cpu_pkg::RC_D;
        p_val[0] = cpu_pkg::RESET_WORD;
        p_val[1] = cpu_pkg::RESET_WORD;
        if (op_valid) begin
            unique case (op)
                cpu_pkg::index_ea_op, cpu_pkg::load_ea_op: begin
                    ea_nxt = eab.ea;
                    ea_indirect_nxt = eab.indirect;
                    p_en[0] = eab.step_en;
                    p_code[0] = eab.ptr_code;
                    p_val[0] = eab.ptr_nxt;
                    p_en[1] = op == cpu_pkg::load_ea_op;
                    p_code[1] = lea_code;
                    p_val[1] = eab.ea;
                end
                cpu_pkg::branch_op: begin
                    if (cond_true) begin
                        pc_nxt = pc_r + br_off;
                    end
                end
                cpu_pkg::add8_op, cpu_pkg::add8_carry_op, cpu_pkg::sub8_op,
                cpu_pkg::sub8_borrow_op, cpu_pkg::compare8_op: begin
                    fl_nxt[cpu_pkg::FL_N] = sum9[7];
                    fl_nxt[cpu_pkg::FL_Z] = sum9[7:0] == 8'h00;
                    fl_nxt[cpu_pkg::FL_V] = v8;
                    fl_nxt[cpu_pkg::FL_C] = sum9[8];
                    if (!is_sub) begin
                        fl_nxt[cpu_pkg::FL_H] = h8;
                    end
                    if (op != cpu_pkg::compare8_op) begin
                        if (sel_b) begin
                            b_nxt = sum9[7:0];
                        end else begin
                            a_nxt = sum9[7:0];
                        end
                    end
                end
                cpu_pkg::test8_op: begin
                    fl_nxt[cpu_pkg::FL_N] = src8[7];
                    fl_nxt[cpu_pkg::FL_Z] = src8 == 8'h00;
                    fl_nxt[cpu_pkg::FL_V] = 1'b0;
                end
                cpu_pkg::shift_right_arith_op, cpu_pkg::shift_right_logic_op,
                cpu_pkg::shift_left_op, cpu_pkg::rotate_left_op,
                cpu_pkg::rotate_right_op: begin
                    fl_nxt[cpu_pkg::FL_N] = sh8[7];
                    fl_nxt[cpu_pkg::FL_Z] = sh8 == 8'h00;
                    fl_nxt[cpu_pkg::FL_C] = sh_c;
                    if (op == cpu_pkg::shift_left_op || op == cpu_pkg::rotate_left_op) begin
                        fl_nxt[cpu_pkg::FL_V] = src8[7] ^ src8[6];
                    end
                    if (to_mem) begin
                        wr_en_nxt = 1'b1;
                        wr_addr_nxt = ea_r;
                        wr_data_nxt = {8'h00, sh8};
                    end else if (sel_b) begin
                        b_nxt = sh8;
                    end else begin
                        a_nxt = sh8;
                    end
                end
                cpu_pkg::decimal_adjust_op: begin
                    a_nxt = adj9[7:0];
                    fl_nxt[cpu_pkg::FL_N] = adj9[7];
                    fl_nxt[cpu_pkg::FL_Z] = adj9[7:0] == 8'h00;
                    fl_nxt[cpu_pkg::FL_C] = carry_in | hi_fix;
                end
                cpu_pkg::unsigned_multiply_op: begin
                    {a_nxt, b_nxt} = prod;
                    fl_nxt[cpu_pkg::FL_Z] = prod == 16'h0000;
                    fl_nxt[cpu_pkg::FL_C] = prod[7];
                end
                cpu_pkg::sign_extend_op: begin
                    a_nxt = {8{b_r[7]}};
                    fl_nxt[cpu_pkg::FL_N] = b_r[7];
                    fl_nxt[cpu_pkg::FL_Z] = {a_nxt, b_r} == 16'h0000;
                end
                cpu_pkg::wide_add_op, cpu_pkg::wide_subtract_op, cpu_pkg::wide_compare_op: begin
                    fl_nxt[cpu_pkg::FL_N] = sum17[15];
                    fl_nxt[cpu_pkg::FL_Z] = sum17[15:0] == 16'h0000;
                    fl_nxt[cpu_pkg::FL_V] = v16;
                    fl_nxt[cpu_pkg::FL_C] = sum17[16];
                    if (op != cpu_pkg::wide_compare_op) begin
                        {a_nxt, b_nxt} = sum17[15:0];
                    end
                end
                cpu_pkg::wide_load_op: begin
                    {a_nxt, b_nxt} = operand;
                    fl_nxt[cpu_pkg::FL_N] = operand[15];
                    fl_nxt[cpu_pkg::FL_Z] = operand == 16'h0000;
                    fl_nxt[cpu_pkg::FL_V] = 1'b0;
                end
                cpu_pkg::wide_store_op: begin
                    wr_en_nxt = 1'b1;
                    wr_addr_nxt = ea_r;
                    wr_data_nxt = d_cur;
                    fl_nxt[cpu_pkg::FL_N] = d_cur[15];
                    fl_nxt[cpu_pkg::FL_Z] = d_cur == 16'h0000;
                    fl_nxt[cpu_pkg::FL_V] = 1'b0;
                end
                cpu_pkg::register_swap_op, cpu_pkg::register_copy_op: begin
                    // a move between mismatched sizes is ignored
                    p_en[0] = size_match && op == cpu_pkg::register_swap_op;
                    p_code[0] = src_code;
                    p_val[0] = dst_val;
                    p_en[1] = size_match;
                    p_code[1] = dst_code;
                    p_val[1] = src_val;
                end
                cpu_pkg::stack_push_op: begin
                    p_en[0] = 1'b1;
                    p_code[0] = sp_code;
                    p_val[0] = sp_cur - sp_step;
                    wr_en_nxt = 1'b1;
                    wr_addr_nxt = sp_cur - sp_step;
                    wr_data_nxt = push_narrow ? {8'h00, dst_val[7:0]} : dst_val;
                end
                cpu_pkg::stack_pull_op: begin
                    p_en[0] = 1'b1;
                    p_code[0] = sp_code;
                    p_val[0] = sp_cur + sp_step;
                    p_en[1] = 1'b1;
                    p_code[1] = dst_code;
                    p_val[1] = push_narrow ? {8'h00, operand[7:0]} : operand;
                end
                default: ea_nxt = ea_r;
            endcase
        end
        for (int i = 0; i < 2; i++) begin
            if (p_en[i]) begin
                unique case (p_code[i])
                    cpu_pkg::RC_D: {a_nxt, b_nxt} = p_val[i];
                    cpu_pkg::RC_X: x_nxt = p_val[i];
                    cpu_pkg::RC_Y: y_nxt = p_val[i];
                    cpu_pkg::RC_U: u_nxt = p_val[i];
                    cpu_pkg::RC_S: s_nxt = p_val[i];
                    cpu_pkg::RC_PC: pc_nxt = p_val[i];
                    cpu_pkg::RC_A: a_nxt = p_val[i][7:0];
                    cpu_pkg::RC_B: b_nxt = p_val[i][7:0];
                    cpu_pkg::RC_FL: fl_nxt = p_val[i][7:0];
                    cpu_pkg::RC_PG: pg_nxt = p_val[i][7:0];
                    default: ;
                endcase
            end
        end
    end

    // register file and result flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {a_r, b_r, fl_r, pg_r} <= {4{cpu_pkg::RESET_BYTE}};
            {x_r, y_r, u_r, s_r, pc_r} <= {5{cpu_pkg::RESET_WORD}};
            {ea_r, wr_addr_r, wr_data_r} <= {3{cpu_pkg::RESET_WORD}};
            ea_indirect_r <= 1'b0;
            wr_en_r <= 1'b0;
        end else begin
            {a_r, b_r, fl_r, pg_r} <= {a_nxt, b_nxt, fl_nxt, pg_nxt};
            {x_r, y_r, u_r, s_r, pc_r} <= {x_nxt, y_nxt, u_nxt, s_nxt, pc_nxt};
            {ea_r, wr_addr_r, wr_data_r} <= {ea_nxt, wr_addr_nxt, wr_data_nxt};
            ea_indirect_r <= ea_indirect_nxt;
            wr_en_r <= wr_en_nxt;
        end
    end
endmodule : cpu_ea_alu
`default_nettype wire

// [core/cpu_pkg.sv]
package cpu_pkg;

    // operations presented by the instruction decoder
    typedef enum logic [4:0] {
        nop_op = 5'h00,
        index_ea_op = 5'h01,
        load_ea_op = 5'h02,
        branch_op = 5'h03,
        add8_op = 5'h04,
        add8_carry_op = 5'h05,
        sub8_op = 5'h06,
        sub8_borrow_op = 5'h07,
        compare8_op = 5'h08,
        test8_op = 5'h09,
        shift_right_arith_op = 5'h0A,
        shift_right_logic_op = 5'h0B,
        shift_left_op = 5'h0C,
        rotate_left_op = 5'h0D,
        rotate_right_op = 5'h0E,
        decimal_adjust_op = 5'h0F,
        unsigned_multiply_op = 5'h10,
        sign_extend_op = 5'h11,
        wide_add_op = 5'h12,
        wide_subtract_op = 5'h13,
        wide_compare_op = 5'h14,
        wide_load_op = 5'h15,
        wide_store_op = 5'h16,
        register_swap_op = 5'h17,
        register_copy_op = 5'h18,
        stack_push_op = 5'h19,
        stack_pull_op = 5'h1A
    } op_t;

    // postbyte layout of indexed addressing
    localparam int PB_LONG_BIT = 7;
    localparam int PB_IND_BIT = 4;
    localparam int PB_REG_LSB = 5;
    localparam logic [3:0] MODE_INC1 = 4'h0;
    localparam logic [3:0] MODE_INC2 = 4'h1;
    localparam logic [3:0] MODE_DEC1 = 4'h2;
    localparam logic [3:0] MODE_DEC2 = 4'h3;
    localparam logic [3:0] MODE_ZERO = 4'h4;
    localparam logic [3:0] MODE_ACC_B = 4'h5;
    localparam logic [3:0] MODE_ACC_A = 4'h6;
    localparam logic [3:0] MODE_OFF8 = 4'h8;
    localparam logic [3:0] MODE_OFF16 = 4'h9;
    localparam logic [3:0] MODE_ACC_D = 4'hB;
    localparam logic [3:0] MODE_PC8 = 4'hC;
    localparam logic [3:0] MODE_PC16 = 4'hD;
    localparam logic [3:0] MODE_EXT_IND = 4'hF;

    // register codes of swap, copy, push and pull; bit 3 marks 8-bit
    localparam logic [3:0] RC_D = 4'h0;
    localparam logic [3:0] RC_X = 4'h1;
    localparam logic [3:0] RC_Y = 4'h2;
    localparam logic [3:0] RC_U = 4'h3;
    localparam logic [3:0] RC_S = 4'h4;
    localparam logic [3:0] RC_PC = 4'h5;
    localparam logic [3:0] RC_A = 4'h8;
    localparam logic [3:0] RC_B = 4'h9;
    localparam logic [3:0] RC_FL = 4'hA;
    localparam logic [3:0] RC_PG = 4'hB;
    localparam int RC_NARROW_BIT = 3;

    // condition flag positions
    localparam int FL_C = 0;
    localparam int FL_V = 1;
    localparam int FL_Z = 2;
    localparam int FL_N = 3;
    localparam int FL_H = 5;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [15:0] STEP_ONE = 16'h0001;
    localparam logic [15:0] STEP_TWO = 16'h0002;

endpackage : cpu_pkg

// [core/ea_calc.sv]
`timescale 1ns/10ps
`default_nettype none
module ea_calc (
    ea_if.calc bus
);
    wire logic [7:0] pb = bus.postbyte;
    wire logic [3:0] mode = pb[3:0];
    wire logic long_form = pb[cpu_pkg::PB_LONG_BIT];
    wire logic [1:0] rsel = pb[cpu_pkg::PB_REG_LSB +: 2];

    // pointer selection
    wire logic [15:0] ptr = (rsel == 2'h0) ? bus.x : (rsel == 2'h1) ? bus.y :
                            (rsel == 2'h2) ? bus.u : bus.s;
    assign bus.ptr_code = (rsel == 2'h0) ? cpu_pkg::RC_X : (rsel == 2'h1) ? cpu_pkg::RC_Y :
                          (rsel == 2'h2) ? cpu_pkg::RC_U : cpu_pkg::RC_S;

    // sign-extended offsets, all sums wrap at 16 bits
    wire logic [15:0] off5 = {{11{pb[4]}}, pb[4:0]};
    wire logic [15:0] off8 = {{8{bus.operand[7]}}, bus.operand[7:0]};
    wire logic [15:0] off_a = {{8{bus.acc_a[7]}}, bus.acc_a};
    wire logic [15:0] off_b = {{8{bus.acc_b[7]}}, bus.acc_b};
    wire logic [15:0] acc_d = {bus.acc_a, bus.acc_b};

    // auto step: post increment, pre decrement
    wire logic is_step = long_form && (mode <= cpu_pkg::MODE_DEC2);
    wire logic [15:0] step_mag = mode[0] ? cpu_pkg::STEP_TWO : cpu_pkg::STEP_ONE;
    wire logic [15:0] ptr_dec = ptr - step_mag;
    assign bus.ptr_nxt = mode[1] ? ptr_dec : ptr + step_mag;
    assign bus.step_en = is_step;

    logic [15:0] ea_sel;
    always_comb begin
        if (!long_form) begin
            ea_sel = ptr + off5;
        end else begin
            unique case (mode)
                cpu_pkg::MODE_INC1, cpu_pkg::MODE_INC2: ea_sel = ptr;
                cpu_pkg::MODE_DEC1, cpu_pkg::MODE_DEC2: ea_sel = ptr_dec;
                cpu_pkg::MODE_ZERO: ea_sel = ptr;
                cpu_pkg::MODE_ACC_B: ea_sel = ptr + off_b;
                cpu_pkg::MODE_ACC_A: ea_sel = ptr + off_a;
                cpu_pkg::MODE_ACC_D: ea_sel = ptr + acc_d;
                cpu_pkg::MODE_OFF8: ea_sel = ptr + off8;
                cpu_pkg::MODE_OFF16: ea_sel = ptr + bus.operand;
                cpu_pkg::MODE_PC8: ea_sel = bus.pc + off8;
                cpu_pkg::MODE_PC16: ea_sel = bus.pc + bus.operand;
                cpu_pkg::MODE_EXT_IND: ea_sel = bus.operand;
                default: ea_sel = ptr; // unused codes act as zero offset
            endcase
        end
    end
    assign bus.ea = ea_sel;

    // no indirection for single steps or the in-postbyte offset
    assign bus.indirect = long_form && pb[cpu_pkg::PB_IND_BIT] &&
                          mode != cpu_pkg::MODE_INC1 && mode != cpu_pkg::MODE_DEC1;
endmodule : ea_calc
`default_nettype wire

// [core/ea_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface ea_if;
    logic [7:0] postbyte;
    logic [7:0] acc_a;
    logic [7:0] acc_b;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] u;
    logic [15:0] s;
    logic [15:0] pc;
    logic [15:0] operand;
    logic [15:0] ea;
    logic [15:0] ptr_nxt;
    logic [3:0] ptr_code;
    logic indirect;
    logic step_en;
    modport calc(input postbyte, acc_a, acc_b, x, y, u, s, pc, operand,
                 output ea, ptr_nxt, ptr_code, indirect, step_en);
    modport core(output postbyte, acc_a, acc_b, x, y, u, s, pc, operand,
                 input ea, ptr_nxt, ptr_code, indirect, step_en);
endinterface : ea_if
`default_nettype wire

// [tb/cpu_ea_alu_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module cpu_ea_alu_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic op_valid,
    input wire cpu_pkg::op_t op,
    input wire logic [7:0] postbyte,
    input wire logic [15:0] operand,
    input wire logic wide,
    input wire logic cond_true,
    input wire logic [15:0] ea_r,
    input wire logic [15:0] acc_d,
    input wire logic [15:0] index_x,
    input wire logic [15:0] prog_counter
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // an accepted op of one kind
    sequence s_do(cpu_pkg::op_t k);
        op_valid && op == k;
    endsequence
    // indexed op through the first index register, masked postbyte
    sequence s_ix(logic [7:0] m, logic [7:0] v);
        s_do(cpu_pkg::index_ea_op) ##0 (postbyte & m) == v;
    endsequence
    property p_zero;
        s_ix(8'hFF, 8'h84) |=> ea_r == $past(index_x) && $stable(index_x);
    endproperty
    a_zero: assert property (p_zero) else $error("zero offset address wrong");
    property p_off5;
        s_ix(8'hE0, 8'h00) |=> ea_r == $past(index_x) + {{11{$past(postbyte[4])}},
            $past(postbyte[4:0])} && $stable(index_x);
    endproperty
    a_off5: assert property (p_off5) else $error("short offset address wrong");
    property p_inc;
        s_ix(8'hFE, 8'h80) |=> ea_r == $past(index_x)
            && index_x == $past(index_x) + $past(postbyte[0]) + 16'h0001;
    endproperty
    a_inc: assert property (p_inc) else $error("auto step wrong");
    property p_acc;
        s_ix(8'hFF, 8'h85) |=> ea_r == $past(index_x) + {{8{$past(acc_d[7])}},
            $past(acc_d[7:0])} && $stable(acc_d) && $stable(index_x);
    endproperty
    a_acc: assert property (p_acc) else $error("accumulator offset wrong");
    property p_prod;
        s_do(cpu_pkg::unsigned_multiply_op) |=> acc_d == $past(acc_d[15:8]) * $past(acc_d[7:0]);
    endproperty
    a_prod: assert property (p_prod) else $error("product wrong");
    property p_sext;
        s_do(cpu_pkg::sign_extend_op) |=> acc_d == {{8{$past(acc_d[7])}}, $past(acc_d[7:0])};
    endproperty
    a_sext: assert property (p_sext) else $error("sign extend wrong");
    property p_br;
        s_do(cpu_pkg::branch_op) ##0 cond_true |=> prog_counter == $past(prog_counter)
            + ($past(wide) ? $past(operand) : {{8{$past(operand[7])}}, $past(operand[7:0])});
    endproperty
    a_br: assert property (p_br) else $error("taken branch target wrong");
    property p_nobr;
        s_do(cpu_pkg::branch_op) ##0 !cond_true |=> $stable(prog_counter);
    endproperty
    a_nobr: assert property (p_nobr) else $error("untaken branch moved pc");
    property p_cmp;
        s_do(cpu_pkg::compare8_op) |=> $stable(acc_d);
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare changed accumulator");
endmodule : cpu_ea_alu_checker
bind cpu_ea_alu cpu_ea_alu_checker u_cpu_ea_alu_checker (.clk, .reset_n, .op_valid, .op,
    .postbyte, .operand, .wide, .cond_true, .ea_r, .acc_d, .index_x, .prog_counter);
`default_nettype wire

// [tb/test_cpu_ea_alu.sv]
`timescale 1ns/10ps
`default_nettype none
module test_cpu_ea_alu;
    logic clk = 1'b0, reset_n = 1'b0, op_valid = 1'b0, sel_b = 1'b0, to_mem = 1'b0;
    logic wide = 1'b0, cond_true = 1'b0, user_stack = 1'b0, wr_en_r, ea_indirect_r;
    cpu_pkg::op_t op = cpu_pkg::nop_op;
    logic [7:0] postbyte = 8'h00, condition_flags, page_base, pg = 8'h00;
    logic [1:0] lea_dst = 2'h1;
    logic [15:0] operand = 16'h0000, ea_r, wr_addr_r, wr_data_r, acc_d, index_x, index_y;
    logic [15:0] user_sp, hw_sp, prog_counter, d, x, pc, off;
    logic [31:0] seed = 32'h319988BB, r;
    int n_mismatch = 0, num_checks = 0;
    always #10 clk = ~clk;
    cpu_ea_alu u_cpu_ea_alu (.clk, .reset_n, .op_valid, .op, .postbyte, .operand, .sel_b,
        .to_mem, .wide, .cond_true, .user_stack, .lea_dst, .ea_r, .ea_indirect_r, .wr_en_r,
        .wr_addr_r, .wr_data_r, .acc_d, .condition_flags, .page_base, .index_x, .index_y,
        .user_sp, .hw_sp, .prog_counter);
    // xorshift source, fixed seed keeps runs repeatable
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [15:0] sx8(input logic [7:0] v);
        return {{8{v[7]}}, v};
    endfunction : sx8
    // one op held for one clock, then op_valid dropped; results have landed when it returns
    task automatic run(input cpu_pkg::op_t o, input logic [7:0] pb, input logic [15:0] v);
        @(negedge clk);
        {op_valid, op, postbyte, operand} = {1'b1, o, pb, v};
        @(negedge clk);
        op_valid = 1'b0;
    endtask : run
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        pc = 16'h0000;
        // first pass takes the corner values, later passes random ones
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            d = (i == 0) ? 16'hFFFF : r[15:0];
            off = (i == 0) ? 16'h8000 : r[31:16];
            run(cpu_pkg::wide_load_op, 8'h00, d);
            chk(acc_d, d);
            run(cpu_pkg::unsigned_multiply_op, 8'h00, 16'h0000);
            d = d[15:8] * d[7:0];
            chk(acc_d, d);
            run(cpu_pkg::sign_extend_op, 8'h00, 16'h0000);
            x = sx8(d[7:0]);
            chk(acc_d, x);
            run(cpu_pkg::register_copy_op, 8'h01, 16'h0000);
            chk(index_x, x);
            run(cpu_pkg::index_ea_op, {3'h0, off[15:11]}, 16'h0000);
            chk(ea_r, x + {{11{off[15]}}, off[15:11]});
            chk(index_x, x);
            run(cpu_pkg::index_ea_op, 8'h89, off);
            chk(ea_r, x + off);
            run(cpu_pkg::index_ea_op, 8'h81, 16'h0000);
            chk(ea_r, x);
            chk(index_x, x + 16'h0002);
            run(cpu_pkg::wide_store_op, 8'h00, 16'h0000);
            chk({15'h0, wr_en_r}, 16'h0001);
            chk(wr_addr_r, x);
            chk(wr_data_r, x);
            cond_true = r[8];
            run(cpu_pkg::branch_op, 8'h00, {8'h00, (i == 0) ? 8'hFE : r[7:0]});
            pc = pc + (cond_true ? sx8((i == 0) ? 8'hFE : r[7:0]) : 16'h0000);
            chk(prog_counter, pc);
            // pointer load into y, then both stacks and a byte swap
            run(cpu_pkg::load_ea_op, 8'h98, off);
            chk(index_y, x + 16'h0002 + sx8(off[7:0]));
            chk({15'h0, ea_indirect_r}, 16'h0001);
            run(cpu_pkg::stack_push_op, 8'h00, 16'h0000);
            chk(hw_sp, 16'hFFFE - 16'(2 * i));
            user_stack = 1'b1;
            run(cpu_pkg::stack_pull_op, 8'h0A, off);
            user_stack = 1'b0;
            chk({user_sp[7:0], condition_flags}, {8'(i + 1), off[7:0]});
            run(cpu_pkg::register_swap_op, 8'hB8, 16'h0000);
            chk({page_base, acc_d[15:8]}, {x[15:8], pg});
            pg = x[15:8];
        end
        // random back-to-back traffic, watched by the checker
        repeat (300) begin
            @(negedge clk);
            r = rnd();
            {op_valid, sel_b, to_mem, wide, cond_true, user_stack, lea_dst} = r[31:24];
            op = cpu_pkg::op_t'(r[4:0] % 5'd27);
            {postbyte, operand} = {r[15:8], r[23:8]};
        end
        conclude();
    end
endmodule : test_cpu_ea_alu
`default_nettype wire
